// file: rtl/port_regs_pkg.sv
// constants shared by the can-linked port register bank
package port_regs_pkg;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned ADDR_W = 4;
  // register addresses
  localparam logic [3:0] ADDR_INPUT   = 4'h0;
  localparam logic [3:0] ADDR_RISE    = 4'h1;
  localparam logic [3:0] ADDR_FALL    = 4'h2;
  localparam logic [3:0] ADDR_OUT     = 4'h3;
  localparam logic [3:0] ADDR_DRV     = 4'h4;
  localparam logic [3:0] ADDR_ANALOG  = 4'h5;
  localparam logic [3:0] ADDR_SPREAD1 = 4'h6;
  localparam logic [3:0] ADDR_SPREAD2 = 4'h7;
  // analog configuration field positions
  localparam int unsigned SW_LSB   = 5;
  localparam int unsigned MON_LSB  = 8;
  localparam int unsigned CMP_LSB  = 12;
  localparam int unsigned CONV_BIT = 15;
  // pins with special functions
  localparam int unsigned SPREAD1_PIN = 10;
  localparam int unsigned SPREAD2_PIN = 4;
  localparam int unsigned MON1_PIN    = 8;
  localparam int unsigned MON2_PIN    = 9;
  localparam int unsigned MON3_PIN    = 7;
  // reset values and the reserved switch code
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0]  SW_RESERVED = 3'h7;
  // spread pulse length in internal clock periods
  localparam int unsigned PULSE_CLKS = 4;
  localparam int unsigned SPREAD_W   = 10;
endpackage

// file: rtl/pulse_spread_gen.sv
// distributed pulse modulation generator
`timescale 1ns/100ps
module pulse_spread_gen #(
  parameter int unsigned VAL_W = 10
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [VAL_W-1:0] level,
  output logic                  pulse_out
);
  // slot counter and accumulator; one slot is PULSE_CLKS clocks
  logic [1:0]       sub_q;
  logic [VAL_W:0]   acc_q;
  logic             out_q;
  wire              slot_end = (sub_q == 2'(port_regs_pkg::PULSE_CLKS - 1));
  wire  [VAL_W:0]   acc_sum  = {1'b0, acc_q[VAL_W-1:0]} + {1'b0, level};

  // an accumulator overflow marks an evenly spread pulse slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= 2'h0;
      acc_q <= '0;
      out_q <= 1'b0;
    end else begin
      sub_q <= sub_q + 2'h1;
      if (slot_end) begin
        acc_q <= acc_sum;
        out_q <= acc_sum[VAL_W];
      end
    end
  end

  assign pulse_out = out_q;

  chk_pulse_width_four: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(out_q) |-> out_q [*4])
    else $error("spread pulse shorter than four clocks");
endmodule

// file: rtl/can_linked_port_registers.sv
// register bank and port logic of a can-attached remote i/o node
`timescale 1ns/100ps
module can_linked_port_registers #(
  parameter int unsigned PORT_W   = port_regs_pkg::PORT_W,
  parameter int unsigned SPREAD_W = port_regs_pkg::SPREAD_W
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  // received frame from the protocol engine, checked and valid
  input  wire logic              rx_valid,
  input  wire logic              rx_remote,
  input  wire logic [3:0]        rx_addr,
  input  wire logic [15:0]       rx_data,
  // protocol engine status
  input  wire logic              calib_done,
  input  wire logic              signon_req,
  input  wire logic              ctrl_field_sent,
  input  wire logic              tx_done,
  input  wire logic              conv_done,
  // transmit request towards the protocol engine
  output logic                   tx_req,
  output logic [3:0]             tx_addr,
  output logic [15:0]            tx_data,
  output logic                   conv_start,
  // port pins
  input  wire logic [PORT_W-1:0] pin_in,
  input  wire logic [2:0]        comparator_in,
  output logic [PORT_W-1:0]      pin_out,
  output logic [PORT_W-1:0]      pin_oe,
  output logic [5:0]             switch_closed
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  // two-stage release of the asynchronous reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ==========================================================
  // register storage
  logic [PORT_W-1:0] in_q;
  logic [PORT_W-1:0] rise_en_q;
  logic [PORT_W-1:0] fall_en_q;
  logic [PORT_W-1:0] out_val_q;
  logic [PORT_W-1:0] drv_en_q;
  logic [2:0]        sw_sel_q;
  logic [2:0]        mon_en_q;
  logic              conv_q;
  logic [15:0]       spread1_q;
  logic [15:0]       spread2_q;

  // write strobes for data frames only
  wire wr_frame   = rx_valid && !rx_remote;
  wire wr_rise    = wr_frame && (rx_addr == port_regs_pkg::ADDR_RISE);
  wire wr_fall    = wr_frame && (rx_addr == port_regs_pkg::ADDR_FALL);
  wire wr_out     = wr_frame && (rx_addr == port_regs_pkg::ADDR_OUT);
  wire wr_drv     = wr_frame && (rx_addr == port_regs_pkg::ADDR_DRV);
  wire wr_analog  = wr_frame && (rx_addr == port_regs_pkg::ADDR_ANALOG);
  wire wr_spread1 = wr_frame && (rx_addr == port_regs_pkg::ADDR_SPREAD1);
  wire wr_spread2 = wr_frame && (rx_addr == port_regs_pkg::ADDR_SPREAD2);

  // configuration registers; read-only addresses ignore the value bytes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rise_en_q <= '0;
      fall_en_q <= '0;
      out_val_q <= '0;
      drv_en_q  <= '0;
      sw_sel_q  <= 3'h0;
      mon_en_q  <= 3'h0;
      spread1_q <= port_regs_pkg::REG_RESET;
      spread2_q <= port_regs_pkg::REG_RESET;
    end else begin
      if (wr_rise) rise_en_q <= rx_data[PORT_W-1:0];
      if (wr_fall) fall_en_q <= rx_data[PORT_W-1:0];
      if (wr_out) out_val_q <= rx_data[PORT_W-1:0];
      if (wr_drv) drv_en_q <= rx_data[PORT_W-1:0];
      if (wr_analog) begin
        sw_sel_q <= rx_data[port_regs_pkg::SW_LSB +: 3];
        mon_en_q <= rx_data[port_regs_pkg::MON_LSB +: 3];
      end
      if (wr_spread1) spread1_q <= rx_data;
      if (wr_spread2) spread2_q <= rx_data;
    end
  end

  // conversion start bit clears itself when the result is done
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= 1'b0;
    end else if (wr_analog && rx_data[port_regs_pkg::CONV_BIT]) begin
      conv_q <= 1'b1;
    end else if (conv_done) begin
      conv_q <= 1'b0;
    end
  end

  // ==========================================================
  // edge detection and report loading
  logic [PORT_W-1:0] prev_q;
  logic              evt_pend_q;
  logic              evt_armed_q;
  logic              signon_pend_q;
  logic              tx_q;
  wire  [PORT_W-1:0] rise_hit = pin_in & ~prev_q & rise_en_q;
  wire  [PORT_W-1:0] fall_hit = ~pin_in & prev_q & fall_en_q;
  wire               edge_evt = |(rise_hit | fall_hit);
  wire               load_evt = evt_armed_q && !tx_q; // report owns the next slot

  // pending event waits for the control field, then loads the pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q      <= '0;
      in_q        <= '0;
      evt_pend_q  <= 1'b0;
      evt_armed_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
      in_q   <= pin_in;
      if (edge_evt) begin
        evt_pend_q <= 1'b1; // new edge wins over retiring load
      end else if (load_evt) begin
        evt_pend_q <= 1'b0;
      end
      if (load_evt) evt_armed_q <= 1'b0;
      else if (evt_pend_q && ctrl_field_sent) evt_armed_q <= 1'b1;
    end
  end

  // ==========================================================
  // answer path
  logic [3:0]  tx_addr_q;
  logic [15:0] tx_data_q;
  logic        answer_pend_q;
  logic [3:0]  answer_addr_q;
  wire  [15:0] analog_rd = {conv_q, comparator_in, 1'b0, mon_en_q, sw_sel_q, 5'h00};

  // register contents as seen by the answer of a frame
  function automatic logic [15:0] read_reg(input logic [3:0] a, input logic [15:0] ana,
                                           input logic [PORT_W-1:0] ins);
    case (a)
      port_regs_pkg::ADDR_INPUT:   read_reg = 16'(ins);
      port_regs_pkg::ADDR_RISE:    read_reg = 16'(rise_en_q);
      port_regs_pkg::ADDR_FALL:    read_reg = 16'(fall_en_q);
      port_regs_pkg::ADDR_OUT:     read_reg = 16'(out_val_q);
      port_regs_pkg::ADDR_DRV:     read_reg = 16'(drv_en_q);
      port_regs_pkg::ADDR_ANALOG:  read_reg = ana;
      port_regs_pkg::ADDR_SPREAD1: read_reg = spread1_q;
      port_regs_pkg::ADDR_SPREAD2: read_reg = spread2_q;
      default:                     read_reg = 16'h0000;
    endcase
  endfunction

  // queued answer address for every received frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      answer_pend_q <= 1'b0;
      answer_addr_q <= 4'h0;
    end else if (rx_valid) begin
      answer_pend_q <= 1'b1;
      answer_addr_q <= rx_addr;
    end else if (answer_pend_q && !tx_q) begin
      answer_pend_q <= 1'b0;
    end
  end

  // one request at a time; events first and discard a waiting answer; then answers, then sign-on
  wire load_answer = answer_pend_q && !tx_q && !load_evt;
  wire load_signon = signon_pend_q && calib_done && !tx_q && !load_evt && !answer_pend_q;

  // sign-on waits for calibration; cleared only when actually loaded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      signon_pend_q <= 1'b0;
    end else if (signon_req) begin
      signon_pend_q <= 1'b1;
    end else if (load_signon) begin
      signon_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_q      <= 1'b0;
      tx_addr_q <= 4'h0;
      tx_data_q <= 16'h0000;
    end else if (load_evt || load_signon) begin
      tx_q      <= 1'b1;
      tx_addr_q <= port_regs_pkg::ADDR_INPUT;
      tx_data_q <= 16'(pin_in);
    end else if (load_answer) begin
      tx_q      <= 1'b1;
      tx_addr_q <= answer_addr_q;
      tx_data_q <= read_reg(answer_addr_q, analog_rd, pin_in);
    end else if (tx_done) begin
      tx_q <= 1'b0;
    end
  end

  // ==========================================================
  // output pins
  logic              sp1;
  logic              sp2;
  logic [PORT_W-1:0] pin_out_q;
  logic [PORT_W-1:0] pin_oe_q;
  logic [6:0]        sw_q;
  logic              conv_start_q;
  logic [PORT_W-1:0] pin_mux;

  pulse_spread_gen #(.VAL_W(SPREAD_W)) u_spread1 (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (spread1_q[SPREAD_W-1:0]),
    .pulse_out (sp1)
  );

  pulse_spread_gen #(.VAL_W(SPREAD_W)) u_spread2 (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (spread2_q[SPREAD_W-1:0]),
    .pulse_out (sp2)
  );

  // per-pin source selection: data, monitors, spread outputs
  always_comb begin
    pin_mux = out_val_q;
    if (mon_en_q[0]) pin_mux[port_regs_pkg::MON1_PIN] = comparator_in[0];
    if (mon_en_q[1]) pin_mux[port_regs_pkg::MON2_PIN] = comparator_in[1];
    if (mon_en_q[2]) pin_mux[port_regs_pkg::MON3_PIN] = comparator_in[2];
    if (|spread1_q) begin
      pin_mux[port_regs_pkg::SPREAD1_PIN] = sp1 ^ out_val_q[port_regs_pkg::SPREAD1_PIN];
    end
    if (|spread2_q) begin
      pin_mux[port_regs_pkg::SPREAD2_PIN] = sp2 ^ out_val_q[port_regs_pkg::SPREAD2_PIN];
    end
  end

  // switch decode: one-hot, none for zero or reserved code
  wire [6:0] sw_dec = (sw_sel_q == port_regs_pkg::SW_RESERVED) ? 7'h00 :
                      (7'h01 << sw_sel_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q    <= '0;
      pin_oe_q     <= '0;
      sw_q         <= 7'h00;
      conv_start_q <= 1'b0;
    end else begin
      pin_out_q    <= pin_mux;
      pin_oe_q     <= drv_en_q;
      sw_q         <= sw_dec;
      conv_start_q <= wr_analog && rx_data[port_regs_pkg::CONV_BIT];
    end
  end

  assign tx_req        = tx_q;
  assign tx_addr       = tx_addr_q;
  assign tx_data       = tx_data_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign switch_closed = sw_q[6:1];
  assign conv_start    = conv_start_q;

  // ==========================================================
  // checks
  chk_write_out_applied: assert property (@(posedge clock) disable iff (!rst_n)
    wr_out ##1 !wr_out |=> pin_out_q == $past(rx_data[PORT_W-1:0], 2) ||
                           (|spread1_q) || (|spread2_q) || (|mon_en_q))
    else $error("output data not applied");
  chk_oe_follows_reg: assert property (@(posedge clock) disable iff (!rst_n)
    wr_drv |=> ##1 pin_oe_q == $past(rx_data[PORT_W-1:0], 2))
    else $error("driver enable not applied");
  chk_switch_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot0(sw_q[6:1]))
    else $error("more than one switch closed");
  chk_answer_queued: assert property (@(posedge clock) disable iff (!rst_n)
    rx_valid |=> answer_pend_q || tx_q)
    else $error("frame not answered");
  chk_conv_clears: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done && !(wr_analog && rx_data[port_regs_pkg::CONV_BIT]) |=> !conv_q)
    else $error("conversion bit not cleared");
  chk_signon_calib: assert property (@(posedge clock) disable iff (!rst_n)
    signon_pend_q && !calib_done && !evt_armed_q && !answer_pend_q && !tx_q |=> !tx_q)
    else $error("sign-on before calibration");
  sequence evt_seen_s;
    edge_evt && !evt_pend_q;
  endsequence
  chk_event_pending: assert property (@(posedge clock) disable iff (!rst_n)
    evt_seen_s |=> evt_pend_q && !evt_armed_q)
    else $error("event not held pending");
  chk_event_load_live: assert property (@(posedge clock) disable iff (!rst_n)
    load_evt |=> tx_data_q == 16'($past(pin_in)))
    else $error("report not refreshed with live pins");
endmodule

// file: tb/host_engine_model.sv
// behavioural protocol engine serving the transmit requests of the port block
`timescale 1ns/100ps
module host_engine_model (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic tx_req,
  input  wire logic slow,
  input  wire logic report_go,
  output logic      ctrl_field_sent,
  output logic      tx_done
);
  int cf_q;
  int tx_q;
  // control field leaves some cycles after a report starts; a frame ends later
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cf_q <= 0;
      tx_q <= 0;
      ctrl_field_sent <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      ctrl_field_sent <= (cf_q == 1);
      if (report_go)
        cf_q <= slow ? 12 : 2;
      else if (cf_q > 0)
        cf_q <= cf_q - 1;
      tx_done <= (tx_q == 1) && !tx_done;
      if (!tx_req || tx_done)
        tx_q <= 0;
      else if (tx_q == 0)
        tx_q <= slow ? 9 : 2;
      else if (tx_q > 1)
        tx_q <= tx_q - 1;
    end
  end
endmodule

// file: tb/can_linked_port_registers_bench.sv
// self-checking bench for the can-linked port register bank
`timescale 1ns/100ps
module can_linked_port_registers_bench;
  localparam int SW  = 4;
  localparam int PER = (1 << SW) * 4;
  logic        clock, reset_n, rx_valid, rx_remote, calib_done, signon_req, conv_done;
  logic        slow, report_go, ctrl_field_sent, tx_done, tx_req, conv_start;
  logic [3:0]  rx_addr, tx_addr, ev;
  logic [15:0] rx_data, tx_data, pin_in, pin_out, pin_oe, v;
  logic [2:0]  comparator_in;
  logic [5:0]  switch_closed;
  int          seed, fail_count, comparisons, cycles, conv_seen, n, hi, p;
  logic [3:0]  ev_tab [6] = '{4'hb, 4'h8, 4'h5, 4'h6, 4'hf, 4'hd};

  can_linked_port_registers #(.SPREAD_W(SW)) u_dut (
    .clock(clock), .reset_n(reset_n), .rx_valid(rx_valid), .rx_remote(rx_remote),
    .rx_addr(rx_addr), .rx_data(rx_data), .calib_done(calib_done),
    .signon_req(signon_req), .ctrl_field_sent(ctrl_field_sent), .tx_done(tx_done),
    .conv_done(conv_done), .tx_req(tx_req), .tx_addr(tx_addr), .tx_data(tx_data),
    .conv_start(conv_start), .pin_in(pin_in), .comparator_in(comparator_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .switch_closed(switch_closed));
  host_engine_model u_host (
    .clock(clock), .reset_n(reset_n), .tx_req(tx_req), .slow(slow),
    .report_go(report_go), .ctrl_field_sent(ctrl_field_sent), .tx_done(tx_done));

  // ==========================================================
  // clock, hang guard and helpers
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // cycle ceiling and conversion start pulse counter
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1)
      conv_seen <= conv_seen + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_req(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clock);
      got = (tx_req === 1'b1);
    end
  endtask
  task automatic quiet(input int lim);
    logic got;
    wait_req(lim, got);
    check({15'h0000, got}, 16'h0000);
  endtask
  task automatic answer(input logic [3:0] a, input logic [15:0] d);
    logic got;
    wait_req(40, got);
    check({15'h0000, got}, 16'h0001);
    check({12'h000, tx_addr}, {12'h000, a});
    check(tx_data, d);
    for (int i = 0; i < 40 && tx_req !== 1'b0; i++)
      @(negedge clock);
  endtask
  // one received frame: address byte then the two value bytes as one word
  task automatic frame(input logic rem, input logic [3:0] a, input logic [15:0] d);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_remote = rem;
    rx_addr = a;
    rx_data = d;
    @(negedge clock);
    rx_valid = 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
    frame(1'b0, a, d);
    answer(a, exp);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rx_valid, rx_remote, signon_req, conv_done, slow, report_go} = 6'h00;
    {fail_count, comparisons, cycles, conv_seen} = '0;
    seed = 16;
    reset_n = 1'b0;
    calib_done = 1'b1;
    rx_addr = 4'h0;
    rx_data = 16'h0000;
    pin_in = 16'($random(seed));
    comparator_in = 3'($random(seed));
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    // polling, read-only and unmapped places
    wr(port_regs_pkg::ADDR_INPUT, 16'ha5a5, pin_in);
    frame(1'b1, port_regs_pkg::ADDR_INPUT, 16'h0000);
    answer(port_regs_pkg::ADDR_INPUT, pin_in);
    v = 16'($random(seed));
    wr(4'h9, v, 16'h0000);
    // driver enables and output data
    wr(port_regs_pkg::ADDR_DRV, v, v);
    check(pin_oe, v);
    v = 16'($random(seed));
    wr(port_regs_pkg::ADDR_OUT, v, v);
    check(pin_out, v);
    wr(port_regs_pkg::ADDR_DRV, 16'hffff, 16'hffff);
    // switch codes with comparator read-back
    for (int c = 0; c < 8; c++) begin
      comparator_in = 3'($random(seed));
      wr(port_regs_pkg::ADDR_ANALOG, {8'h00, 3'(c), 5'h00},
         {1'b0, comparator_in, 4'h0, 3'(c), 5'h00});
      check({10'h000, switch_closed}, (c == 0 || c == 7) ? 16'h0000 : 16'(1 << (c - 1)));
    end
    wr(port_regs_pkg::ADDR_ANALOG, 16'h0700, {1'b0, comparator_in, 12'h700});
    check({13'h0000, pin_out[7], pin_out[9], pin_out[8]}, {13'h0000, comparator_in});
    // conversion start, then self clearing after the result
    n = conv_seen;
    wr(port_regs_pkg::ADDR_ANALOG, 16'h8000, {1'b1, comparator_in, 12'h000});
    check(16'(conv_seen - n), 16'h0001);
    @(negedge clock);
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
    frame(1'b1, port_regs_pkg::ADDR_ANALOG, 16'h0000);
    answer(port_regs_pkg::ADDR_ANALOG, {1'b0, comparator_in, 12'h000});
    // both spread outputs, plain and inverted
    for (int k = 0; k < 4; k++) begin
      n = ($random(seed) & 7) + 1 + k;
      p = k[0] ? port_regs_pkg::SPREAD2_PIN : port_regs_pkg::SPREAD1_PIN;
      v = k[1] ? 16'h0410 : 16'h0000;
      ev = k[0] ? port_regs_pkg::ADDR_SPREAD2 : port_regs_pkg::ADDR_SPREAD1;
      wr(port_regs_pkg::ADDR_OUT, v, v);
      wr(ev, 16'(n), 16'(n));
      hi = 0;
      repeat (PER) begin
        @(negedge clock);
        hi += (pin_out[p] === 1'b1);
      end
      check(16'(hi), 16'(k[1] ? PER - 4 * n : 4 * n));
      wr(ev, 16'h0000, 16'h0000);
    end
    // edge capture table: rise enable, fall enable, direction, report expected
    slow = 1'b1;
    foreach (ev_tab[i]) begin
      ev = ev_tab[i];
      p = $random(seed) & 15;
      pin_in[p] = ~ev[1];
      repeat (4) @(negedge clock);
      v = ev[3] ? 16'(1 << p) : 16'h0000;
      wr(port_regs_pkg::ADDR_RISE, v, v);
      v = ev[2] ? 16'(1 << p) : 16'h0000;
      wr(port_regs_pkg::ADDR_FALL, v, v);
      check(pin_oe, 16'hffff);
      pin_in[p] = ev[1];
      report_go = 1'b1;
      @(negedge clock);
      report_go = 1'b0;
      quiet(6);
      pin_in[(p + 5) & 15] = ~pin_in[(p + 5) & 15];
      if (ev[0])
        answer(port_regs_pkg::ADDR_INPUT, pin_in);
      else
        quiet(30);
      wr(port_regs_pkg::ADDR_RISE, 16'h0000, 16'h0000);
      wr(port_regs_pkg::ADDR_FALL, 16'h0000, 16'h0000);
    end
    slow = 1'b0;
    // sign-on waits for calibration
    calib_done = 1'b0;
    signon_req = 1'b1;
    @(negedge clock);
    signon_req = 1'b0;
    quiet(20);
    calib_done = 1'b1;
    answer(port_regs_pkg::ADDR_INPUT, pin_in);
    results();
  end
endmodule
